// file: src/serial_packer_params.svh
// Offsets, field positions, reset values and timing counts of the serial data packer
`ifndef SERIAL_PACKER_PARAMS_SVH
`define SERIAL_PACKER_PARAMS_SVH

// Register byte offsets on the AXI4-Lite bus
`define REG_PACKET_LENGTH   8'h00
`define REG_MARKER_CHARS    8'h04
`define REG_MARKER_MODE     8'h08
`define REG_FORCE_TIME      8'h0C
`define REG_STATUS          8'h10
`define REG_FRAME_COUNT     8'h14

// Field positions
`define MARKER_FIRST_LSB    0
`define MARKER_SECOND_LSB   8
`define STATUS_DRAIN_BIT    16

// Reset values
`define PACKET_LENGTH_RESET 11'h000
`define MARKER_RESET        8'h00
`define FORCE_TIME_RESET    16'h0000

// Buffer size in bytes
`define BUFFER_BYTES        11'h400

// Timing: clock rate and the millisecond tick of the idle timeout
`define CLOCK_HZ            25000000
`define TICK_MS             1
`define CYCLES_PER_TICK     ((`CLOCK_HZ / 1000) * `TICK_MS)

// AXI responses
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// file: src/serial_packer_pkg.sv
// Types shared by the serial data packer
package serial_packer_pkg;

  typedef enum logic [0:0] {
    COLLECT = 1'b0,
    DRAIN   = 1'b1
  } pack_state_type;

  typedef enum logic [1:0] {
    EMIT_WITH_MARKER = 2'b00,
    MARKER_PLUS_ONE  = 2'b01,
    MARKER_PLUS_TWO  = 2'b10,
    DROP_MARKER      = 2'b11
  } marker_mode_type;

endpackage

// file: src/serial_data_packer.sv
// Serial byte packer: buffers serial bytes and hands them out as network frames
// Summary of operation
// [RULE_01] Packet length zero sets no length limit on a frame.
// [RULE_02] Packet length 1 to 1024 closes the frame at exactly that fill.
// [RULE_03] Two 8-bit marker characters; zero means unused, both zero disables markers.
// [RULE_04] No markers and nothing else pending: each byte leaves at once.
// [RULE_05] With markers set, bytes accumulate until the marker arrives.
// [RULE_06] Markers work only when the first marker is non-zero.
// [RULE_07] Two markers: first then directly second byte trigger the handling.
// [RULE_08] A full 1K buffer is sent whole and then cleared.
// [RULE_09] Emit mode sends the frame the moment the marker arrives.
// [RULE_10] Plus-one and plus-two modes wait one or two more bytes.
// [RULE_11] Drop mode removes the marker bytes from the frame.
// [RULE_12] Force-transmit time zero disables the idle timeout.
// [RULE_13] Force-transmit time 1 to 65535 ms closes the frame after idle.
// [RULE_14] Software should set the timeout longer than one character time.
// [RULE_15] The sender keeps gaps under the timeout and frames within 1 KB.
// [RULE_16] Coinciding close conditions give one frame and a full restart.
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "serial_packer_params.svh"

module serial_data_packer #(
  parameter int CYCLES_PER_MS = `CYCLES_PER_TICK
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  ser_data,
  input  wire logic        ser_valid,
  output logic             ser_ready,
  output logic [7:0]       net_data,
  output logic             net_valid,
  output logic             net_last,
  input  wire logic        net_ready
);

  // ==========================================================================
  // Declarations
  logic [10:0]                       packet_length;
  logic [7:0]                        marker_first;
  logic [7:0]                        marker_second;
  serial_packer_pkg::marker_mode_type marker_mode;
  logic [15:0]                       force_time;
  logic [31:0]                       frame_count;
  serial_packer_pkg::pack_state_type state;
  serial_packer_pkg::pack_state_type next_state;
  logic [7:0]                        buffer_mem [0:1023];
  logic [10:0]                       fill;
  logic [10:0]                       next_fill;
  logic [10:0]                       emit_len;
  logic [10:0]                       rd_ptr;
  logic                              armed;
  logic                              tail_active;
  logic [1:0]                        tail_left;
  logic [15:0]                       idle_ms;
  logic [31:0]                       tick_cnt;
  logic [31:0]                       rd_word;
  logic [7:0]                        prev_byte;
  logic                              prev_seen;
  // One-bit strobes and close conditions
  logic                              ms_tick, accept, marker_hit, wr_en, rd_en, out_take, last_sent, rd_hit;
  logic                              length_close, full_close, marker_close, tail_close, pass_close;
  logic                              timeout_close, close;

  // ==========================================================================
  // AXI4-Lite write: address and data are taken together, one write at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
    end
  end

  assign wr_en = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

  // Write response; unmapped or read-only offsets answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else if (wr_en) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (s_axi_awaddr <= `REG_FORCE_TIME && s_axi_awaddr[1:0] == 2'h0) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Configuration registers, byte lanes honoured
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      packet_length <= `PACKET_LENGTH_RESET;
      marker_first  <= `MARKER_RESET;
      marker_second <= `MARKER_RESET;
      marker_mode   <= serial_packer_pkg::EMIT_WITH_MARKER;
      force_time    <= `FORCE_TIME_RESET;
    end else if (wr_en) begin
      unique case (s_axi_awaddr)
        `REG_PACKET_LENGTH: begin
          if (s_axi_wstrb[0]) packet_length[7:0] <= s_axi_wdata[7:0];
          if (s_axi_wstrb[1]) packet_length[10:8] <= s_axi_wdata[10:8];
        end
        `REG_MARKER_CHARS: begin
          if (s_axi_wstrb[0]) marker_first <= s_axi_wdata[`MARKER_FIRST_LSB +: 8];
          if (s_axi_wstrb[1]) marker_second <= s_axi_wdata[`MARKER_SECOND_LSB +: 8];
        end
        `REG_MARKER_MODE: begin
          if (s_axi_wstrb[0]) marker_mode <= serial_packer_pkg::marker_mode_type'(s_axi_wdata[1:0]);
        end
        `REG_FORCE_TIME: begin
          if (s_axi_wstrb[0]) force_time[7:0] <= s_axi_wdata[7:0];
          if (s_axi_wstrb[1]) force_time[15:8] <= s_axi_wdata[15:8];
        end
        default: begin
        end
      endcase
    end
  end

  // Read mux
  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (s_axi_araddr)
      `REG_PACKET_LENGTH: rd_word = {21'h000000, packet_length};
      `REG_MARKER_CHARS:  rd_word = {16'h0000, marker_second, marker_first};
      `REG_MARKER_MODE:   rd_word = {30'h00000000, marker_mode};
      `REG_FORCE_TIME:    rd_word = {16'h0000, force_time};
      `REG_STATUS:        rd_word = {15'h0000, (state == serial_packer_pkg::DRAIN), 5'h00, fill};
      `REG_FRAME_COUNT:   rd_word = frame_count;
      default:            rd_hit = 1'b0;
    endcase
  end

  // AXI4-Lite read channel, one read at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Close conditions, evaluated on the byte being taken; the idle timeout only when no byte is taken
  assign accept     = ser_valid && ser_ready;
  assign next_fill  = fill + 11'h001;
  // Second marker only counts right after the first; zero first marker disables all
  assign marker_hit = (marker_first != 8'h00) &&                                   // [RULE_03] [RULE_06]
                      ((marker_second == 8'h00) ? (ser_data == marker_first)
                                                : (armed && ser_data == marker_second)); // [RULE_07]
  assign length_close  = (packet_length != 11'h000) && (next_fill == packet_length); // [RULE_01] [RULE_02]
  assign full_close    = (next_fill == `BUFFER_BYTES);                              // [RULE_08]
  assign marker_close  = marker_hit && !tail_active &&
                         (marker_mode == serial_packer_pkg::EMIT_WITH_MARKER ||    // [RULE_09]
                          marker_mode == serial_packer_pkg::DROP_MARKER);          // [RULE_11]
  assign tail_close    = tail_active && (tail_left == 2'h1);                        // [RULE_10]
  // Nothing configured: every byte is its own frame
  assign pass_close    = (marker_first == 8'h00) && (packet_length == 11'h000) &&
                         (force_time == 16'h0000);                                  // [RULE_04]
  assign timeout_close = !accept && (force_time != 16'h0000) && (fill != 11'h000) &&
                         (idle_ms >= force_time);                                   // [RULE_12] [RULE_13]
  assign close = (state == serial_packer_pkg::COLLECT) &&
                 ((accept && (length_close || full_close || marker_close || tail_close || pass_close)) ||
                  timeout_close);                                                   // [RULE_05] [RULE_16]

  always_comb begin
    next_state = state;
    if (state == serial_packer_pkg::COLLECT && close) begin
      next_state = serial_packer_pkg::DRAIN;
    end else if (state == serial_packer_pkg::DRAIN && last_sent) begin
      next_state = serial_packer_pkg::COLLECT;
    end
  end

  // State and the serial ready flop; serial input stalls while a frame drains
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state     <= serial_packer_pkg::COLLECT;
      ser_ready <= 1'b0;
    end else begin
      state     <= next_state;
      ser_ready <= (next_state == serial_packer_pkg::COLLECT);
    end
  end

  // Buffer write
  always_ff @(posedge aclk) begin
    if (accept) begin
      buffer_mem[fill[9:0]] <= ser_data;
    end
  end

  // Fill count and frame length; drop mode trims the marker bytes off the tail
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fill     <= 11'h000;
      emit_len <= 11'h000;
    end else if (close) begin
      fill <= 11'h000;                                                              // [RULE_16]
      if (!accept) begin
        emit_len <= fill;
      end else if (marker_close && marker_mode == serial_packer_pkg::DROP_MARKER) begin
        emit_len <= next_fill - ((marker_second == 8'h00) ? 11'h001 : 11'h002);     // [RULE_11]
      end else begin
        emit_len <= next_fill;
      end
    end else if (accept) begin
      fill <= next_fill;
    end
  end

  // Marker match state and the tail counter of the plus modes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed       <= 1'b0;
      tail_active <= 1'b0;
      tail_left   <= 2'h0;
    end else if (close) begin
      armed       <= 1'b0;                                                          // [RULE_16]
      tail_active <= 1'b0;
      tail_left   <= 2'h0;
    end else if (accept) begin
      armed <= (marker_first != 8'h00) && (ser_data == marker_first);
      if (tail_active) begin
        tail_left <= tail_left - 2'h1;
      end else if (marker_hit && marker_mode == serial_packer_pkg::MARKER_PLUS_ONE) begin
        tail_active <= 1'b1;                                                        // [RULE_10]
        tail_left   <= 2'h1;
      end else if (marker_hit && marker_mode == serial_packer_pkg::MARKER_PLUS_TWO) begin
        tail_active <= 1'b1;                                                        // [RULE_10]
        tail_left   <= 2'h2;
      end
    end
  end

  // ==========================================================================
  // Idle timer: millisecond divider restarted by each byte, so idle is measured from it
  assign ms_tick = (tick_cnt == 32'(CYCLES_PER_MS - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn || accept || close) begin
      tick_cnt <= 32'h0000_0000;
    end else if (ms_tick) begin
      tick_cnt <= 32'h0000_0000;
    end else begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
    end
  end

  // Saturating count of whole idle milliseconds
  always_ff @(posedge aclk) begin
    if (!aresetn || accept || close) begin
      idle_ms <= 16'h0000;                                                          // [RULE_13]
    end else if (ms_tick && idle_ms != 16'hFFFF) begin
      idle_ms <= idle_ms + 16'h0001;
    end
  end

  // ==========================================================================
  // Frame output: buffer read straight into the output flops
  assign out_take  = net_valid && net_ready;
  assign rd_en     = (state == serial_packer_pkg::DRAIN) && (rd_ptr != emit_len) && (!net_valid || net_ready);
  // An empty frame after drop leaves at once with nothing sent
  assign last_sent = (rd_ptr == emit_len) && (!net_valid || out_take);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      net_valid <= 1'b0;
      net_last  <= 1'b0;
      net_data  <= 8'h00;
      rd_ptr    <= 11'h000;
    end else if (close) begin
      rd_ptr <= 11'h000;
    end else if (rd_en) begin
      net_valid <= 1'b1;
      net_data  <= buffer_mem[rd_ptr[9:0]];
      net_last  <= (rd_ptr + 11'h001 == emit_len);
      rd_ptr    <= rd_ptr + 11'h001;
    end else if (out_take) begin
      net_valid <= 1'b0;
      net_last  <= 1'b0;
    end
  end

  // Frames handed out, counted at their last byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_count <= 32'h0000_0000;
    end else if (out_take && net_last) begin
      frame_count <= frame_count + 32'h0000_0001;
    end
  end

  // ==========================================================================
  // Assertions
  // Last byte of this frame, tracked apart from armed so the pair check does not lean on it
  always_ff @(posedge aclk) begin
    if (!aresetn || close) begin
      prev_seen <= 1'b0;
      prev_byte <= 8'h00;
    end else if (accept) begin
      prev_seen <= 1'b1;
      prev_byte <= ser_data;
    end
  end

  // Drop mode may trim up to two bytes, so the bound is added on the left to avoid a wrap
  length_close_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_02]
    (state == serial_packer_pkg::COLLECT && accept && packet_length != 11'h000 && next_fill == packet_length)
      |=> (state == serial_packer_pkg::DRAIN && emit_len + 11'h002 >= $past(next_fill)))
    else $error("length limit did not close the frame");
  no_length_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_01]
    (state == serial_packer_pkg::COLLECT && accept && packet_length == 11'h000 && marker_first != 8'h00 &&
     !marker_hit && !tail_active && next_fill < `BUFFER_BYTES) |=> state == serial_packer_pkg::COLLECT)
    else $error("frame closed with no length limit and no cause");
  marker_off_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_06]
    (state == serial_packer_pkg::COLLECT && accept && fill == 11'h000 && marker_first == 8'h00 &&
     packet_length == 11'h000 && force_time == 16'h0000)
      |=> (state == serial_packer_pkg::DRAIN && emit_len == 11'h001))
    else $error("second marker acted without a first marker");
  pair_order_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_07]
    (accept && marker_hit && marker_second != 8'h00) |-> (prev_seen && prev_byte == marker_first))
    else $error("two-byte marker matched out of order");
  pass_through_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_04]
    (state == serial_packer_pkg::COLLECT && accept && pass_close) |=> (emit_len == 11'h001) ##1 net_valid)
    else $error("byte not forwarded at once");
  full_buffer_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_08]
    (state == serial_packer_pkg::COLLECT && accept && next_fill == `BUFFER_BYTES && !marker_close)
      |=> (emit_len == `BUFFER_BYTES && fill == 11'h000))
    else $error("full buffer not sent whole");
  emit_marker_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_09]
    (state == serial_packer_pkg::COLLECT && accept && marker_close &&
     marker_mode == serial_packer_pkg::EMIT_WITH_MARKER)
      |=> (state == serial_packer_pkg::DRAIN && emit_len == $past(next_fill)))
    else $error("emit mode did not send at the marker");
  tail_wait_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_10]
    (state == serial_packer_pkg::COLLECT && accept && marker_hit && !tail_active &&
     marker_mode == serial_packer_pkg::MARKER_PLUS_TWO && !length_close && !full_close && !pass_close)
      |=> (tail_active && tail_left == 2'h2 && state == serial_packer_pkg::COLLECT))
    else $error("plus mode sent before its extra bytes");
  drop_marker_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_11]
    (state == serial_packer_pkg::COLLECT && accept && marker_close && marker_second == 8'h00 &&
     marker_mode == serial_packer_pkg::DROP_MARKER) |=> emit_len == $past(fill))
    else $error("marker byte not dropped");
  timeout_off_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_12]
    (state == serial_packer_pkg::COLLECT && !accept && force_time == 16'h0000)
      |=> state == serial_packer_pkg::COLLECT)
    else $error("idle timeout fired while disabled");
  timeout_fire_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_13]
    (state == serial_packer_pkg::COLLECT && timeout_close)
      |=> (state == serial_packer_pkg::DRAIN && emit_len == $past(fill)))
    else $error("idle timeout did not send the buffer");
  single_close_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_16]
    close |=> (fill == 11'h000 && !armed && !tail_active && idle_ms == 16'h0000 && !ser_ready))
    else $error("close did not restart the packer");
endmodule

// file: dv/serial_packer_partner.sv
// Partner model: serial byte source and stalling network sink of the packer
`timescale 1ns/100ps

module serial_packer_partner (
  input  wire logic       aclk,
  output logic [7:0]      ser_data,
  output logic            ser_valid,
  input  wire logic       ser_ready,
  input  wire logic [7:0] net_data,
  input  wire logic       net_valid,
  input  wire logic       net_last,
  output logic            net_ready
);
  logic [7:0] got_q[$];
  int         len_q[$];
  int         cnt;
  logic [1:0] cyc;

  initial begin
    ser_data  = 8'h00;
    ser_valid = 1'b0;
    net_ready = 1'b0;
    cnt       = 0;
    cyc       = 2'h0;
  end

  // ==========================================================
  // Serial source: byte held until taken, gaps far below the idle time
  task automatic send(input logic [7:0] b);
    @(posedge aclk);
    ser_data  <= b;
    ser_valid <= 1'b1;
    do @(posedge aclk); while (ser_ready !== 1'b1);
    ser_valid <= 1'b0;
    ser_data  <= ~b; // Released line must not keep showing the last byte
  endtask

  // ==========================================================
  // Network sink: stalls one cycle in three so held outputs get exercised
  always @(posedge aclk) begin
    cyc       <= (cyc == 2'h2) ? 2'h0 : cyc + 2'h1;
    net_ready <= (cyc != 2'h2);
    if (net_valid === 1'b1 && net_ready) begin
      got_q.push_back(net_data);
      cnt = cnt + 1;
      if (net_last === 1'b1) begin
        len_q.push_back(cnt);
        cnt = 0;
      end
    end
  end
endmodule

// file: dv/serial_data_packer_test.sv
// Self-checking bench of the serial data packer: registers over AXI4-Lite, frames via the partner
`timescale 1ns/100ps
`include "serial_packer_params.svh"

module serial_data_packer_test;
  localparam int MS = 10; // Short millisecond keeps idle timeouts brief
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, ser_valid, ser_ready, net_valid, net_last, net_ready;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [7:0]  ser_data, net_data;
  int          error_cnt = 0;
  int          n_checks = 0;
  int          nf = 0;
  logic [7:0]  eb[$];

  serial_data_packer #(.CYCLES_PER_MS(MS)) serial_data_packer_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ser_data(ser_data), .ser_valid(ser_valid), .ser_ready(ser_ready),
    .net_data(net_data), .net_valid(net_valid), .net_last(net_last), .net_ready(net_ready));

  serial_packer_partner serial_packer_partner_inst (
    .aclk(aclk), .ser_data(ser_data), .ser_valid(ser_valid), .ser_ready(ser_ready),
    .net_data(net_data), .net_valid(net_valid), .net_last(net_last), .net_ready(net_ready));

  initial forever #20 aclk = ~aclk;

  // ==========================================================
  // Compare, verdict and watchdog
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %0h, seen %0h", nm, e, g);
    end
  endtask

  task automatic results;
    $display("checks %0d, errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Whole run needs some five thousand cycles; far beyond that means a hang
  initial begin
    #3000000;
    error_cnt++;
    results();
  end

  // ==========================================================
  // AXI4-Lite master: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (awready === 1'b1) aw = 1'b0;
      if (wready === 1'b1) w = 1'b0;
      awvalid <= aw;
      wvalid  <= w;
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", er, bresp);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready  <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rdata", ed, rdata);
    chk("rresp", er, rresp);
  endtask

  // ==========================================================
  // Byte traffic and frame comparison against the expected frame lengths and bytes
  task automatic tx(input logic [7:0] q[$]);
    foreach (q[i]) serial_packer_partner_inst.send(q[i]);
  endtask

  task automatic frames(input int lens[$], input logic [7:0] ex[$]);
    int k;
    k = 0;
    while (serial_packer_partner_inst.len_q.size() < lens.size() && k < 3000) begin
      @(posedge aclk);
      k++;
    end
    repeat (30) @(posedge aclk); // Room for a stray extra frame to show up
    chk("frame count", lens.size(), serial_packer_partner_inst.len_q.size());
    foreach (lens[i]) chk("frame length", lens[i], serial_packer_partner_inst.len_q[i]);
    foreach (ex[i]) chk("frame byte", ex[i], serial_packer_partner_inst.got_q[i]);
    nf += lens.size();
    serial_packer_partner_inst.len_q.delete();
    serial_packer_partner_inst.got_q.delete();
  endtask

  // ==========================================================
  // Test sequence
  initial begin
    int l1[4];
    int l2[4];
    l1 = '{2, 3, 4, 1};
    l2 = '{3, 2, 1, 3};
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`REG_PACKET_LENGTH, 32'h0, `RESP_OKAY);
    rd(`REG_MARKER_CHARS, 32'h0, `RESP_OKAY);
    rd(`REG_FORCE_TIME, 32'h0, `RESP_OKAY);
    rd(8'h18, 32'h0, `RESP_SLVERR);
    wr(`REG_STATUS, 32'h1, `RESP_SLVERR);
    tx('{8'h41, 8'h42});
    frames('{1, 1}, '{8'h41, 8'h42});
    wr(`REG_MARKER_CHARS, 32'h0D00, `RESP_OKAY);
    tx('{8'h0D, 8'h41});
    frames('{1, 1}, '{8'h0D, 8'h41});
    wr(`REG_MARKER_CHARS, 32'h0, `RESP_OKAY);
    wr(`REG_PACKET_LENGTH, 32'h3, `RESP_OKAY);
    tx('{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06});
    frames('{3, 3}, '{8'h01, 8'h02, 8'h03, 8'h04});
    wr(`REG_PACKET_LENGTH, 32'h0, `RESP_OKAY);
    wr(`REG_MARKER_CHARS, 32'h0D, `RESP_OKAY);
    tx('{8'h61, 8'h62});
    repeat (200) @(posedge aclk);
    chk("frames before marker", 0, serial_packer_partner_inst.len_q.size());
    rd(`REG_STATUS, 32'h2, `RESP_OKAY);
    tx('{8'h0D});
    frames('{3}, '{8'h61, 8'h62, 8'h0D});
    // One millisecond stays well above the two-cycle byte spacing used here
    wr(`REG_FORCE_TIME, 32'h1, `RESP_OKAY);
    for (int m = 0; m < 4; m++) begin
      wr(`REG_MARKER_MODE, m, `RESP_OKAY);
      tx('{8'h41, 8'h0D, 8'h51, 8'h52, 8'h53});
      eb = '{8'h41, 8'h0D, 8'h51, 8'h52, 8'h53};
      if (m == 3) eb.delete(1);
      frames('{l1[m], l2[m]}, eb);
    end
    wr(`REG_FORCE_TIME, 32'h0, `RESP_OKAY);
    wr(`REG_MARKER_MODE, 32'h0, `RESP_OKAY);
    wr(`REG_MARKER_CHARS, 32'h0A0D, `RESP_OKAY);
    tx('{8'h0A, 8'h0D, 8'h41, 8'h0D, 8'h0A});
    frames('{5}, '{8'h0A, 8'h0D, 8'h41, 8'h0D, 8'h0A});
    // Rising byte values never place the second marker right after the first
    for (int i = 0; i < 1024; i++) serial_packer_partner_inst.send(i[7:0]);
    tx('{8'h0D, 8'h0A});
    frames('{1024, 2}, '{8'h00, 8'h01});
    rd(`REG_FRAME_COUNT, nf, `RESP_OKAY);
    results();
  end
endmodule
